// >>> hdl/scope_sel_pkg.sv
// constants, field layouts and carriers for the scope select / dash block
// assumes a single 125 MHz system clock and strobes synchronous to it
//
// Function
// - phase one with phase_one_strobe captures the command word into staging.
// - scope_choice is eight bits, loaded only when take bit 8 is high.
// - scope_allowance is eight bits, loaded only when privilege bit 16 set.
// - both load at phase two with load, select_load_enable and own bit.
// - drawing_directive loads at phase two with load and directive_load_enable.
// - directive holds z/select controls, take, targets, blink, line type, dash.
// - directive target bits load only when the word's take bit is high.
// - other directive bits are set or cleared individually, J-K style.
// - saved_value_lines carry either choice/allowance or the directive.
// - choice and allowance are one bit per scope.
// - choice is compared against allowance to detect a violation.
// - the violation flag is returned to the command source.
// - blinking gates off all selection in the off half of 5 Hz cycle.
// - active selection and dash code load at phase three with its strobe.
// - a dash pattern after a move starts with a full visible segment.
// - per-line restart resets counters each line, else only on moves.
// - pattern count freezes between lines, advances only while intensified.
// - pattern timebase is 160 MHz divided to 20 MHz then 5 MHz.
// - short, long or short-long-short chosen by variant and dash enable.
// - ten-part cycle; toggle flip-flop flips after parts per wired code.
// - timebase halves for each halving of beam velocity.
// - extent classes set velocity: normal, half, quarter, eighth.
// - intensity level code 0..3 stands for 0, -1, -2, -3 volts.
package scope_sel_pkg;

  // ==========================================================
  // command word and scope registers
  localparam int WORD_W        = 18;
  localparam int SCOPE_N       = 8;
  localparam int SEL_TAKE_BIT  = 8;
  localparam int PRIVILEGE_TAKE_BIT_BIT      = 16;
  localparam int LINE_W        = 12;

  // ==========================================================
  // drawing_directive field positions
  localparam int DIR_Z_TO_SCOPE   = 0;
  localparam int DIR_SEL_TO_SCOPE = 1;
  localparam int DIR_SEL_TO_MINOR = 2;
  localparam int DIR_TAKE         = 3;
  localparam int DIR_TARGET_LSB   = 4;
  localparam int DIR_BLINK        = 12;
  localparam int DIR_LINE_TYPE    = 13;
  localparam int DIR_DASH_EN      = 14;
  localparam int DIR_VARIANT      = 15;
  localparam logic [WORD_W-1:0] DIR_JK_MASK     = 18'h0F00F;
  localparam logic [WORD_W-1:0] DIR_TARGET_MASK = 18'h00FF0;
  localparam logic [WORD_W-1:0] DIR_RESET       = 18'h00000;
  localparam logic [SCOPE_N-1:0] SCOPE_RESET    = 8'h00;

  // ==========================================================
  // timing
  localparam int unsigned CLK_HZ   = 125_000_000;
  localparam int unsigned CLK_MHZ  = 125;
  localparam int unsigned BLINK_HZ = 5;
  localparam int unsigned BLINK_HALF_CYC = CLK_HZ / (2 * BLINK_HZ);
  localparam int unsigned OSC_MHZ  = 160;
  localparam int unsigned DIV_HI   = 8;
  localparam int unsigned DIV_LO   = 4;
  localparam int unsigned TICK_CYC = (CLK_MHZ * DIV_HI * DIV_LO) / OSC_MHZ;
  localparam logic [3:0]  PARTS_LAST = 4'h9;

  // ==========================================================
  // velocity class thresholds, fractions of screen width
  localparam int unsigned SCREEN_W = 4096;
  localparam logic [LINE_W-1:0] EXT_HALF    = 12'(SCREEN_W / 64);
  localparam logic [LINE_W-1:0] EXT_QUARTER = 12'(SCREEN_W / 128);
  localparam logic [LINE_W-1:0] EXT_EIGHTH  = 12'(SCREEN_W / 256);

  // ==========================================================
  // wired dash codes: bit p set flips the toggle after part p
  localparam logic [9:0] PAT_SHORT = 10'h3FF;
  localparam logic [9:0] PAT_LONG  = 10'h210;
  localparam logic [9:0] PAT_SLS   = 10'h273;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [WORD_W-1:0] set_bits;
    logic [WORD_W-1:0] clr_bits;
  } cmd_t;

  typedef struct packed {
    logic variant;
    logic enable;
  } dash_code_t;

  typedef enum logic [1:0] {
    VEL_NORMAL  = 2'b00,
    VEL_HALF    = 2'b01,
    VEL_QUARTER = 2'b10,
    VEL_EIGHTH  = 2'b11
  } vel_class_t;

endpackage

// >>> hdl/scope_select_dash_control.sv
// scope selection, scope_allowance check, blink and dash pattern logic
// assumes phase pulses and strobes synchronous to i_clk_sys
`timescale 1ns/1ps
module scope_select_dash_control
#(
  parameter int unsigned BLINK_HALF_CYC = scope_sel_pkg::BLINK_HALF_CYC
)
(
  // clock and reset
  input  wire logic                      i_clk_sys,
  input  wire logic                      i_rst_b,
  // command cable
  input  wire scope_sel_pkg::cmd_t       i_cmd,
  input  wire logic                      i_ph1,
  input  wire logic                      i_ph2,
  input  wire logic                      i_ph3,
  input  wire logic                      i_phase_one_strobe,
  input  wire logic                      i_phase_three_strobe,
  input  wire logic                      i_load,
  input  wire logic                      i_select_load_enable,
  input  wire logic                      i_directive_load_enable,
  input  wire logic                      i_save_directive,
  // line drawing
  input  wire logic                      i_move,
  input  wire logic                      i_line_start,
  input  wire logic                      i_intensify,
  input  wire logic [11:0]               i_line_extent,
  input  wire logic                      i_restart_segment_each_line,
  // results
  output logic [17:0]                    o_saved_value_lines,
  output logic [17:0]                    o_directive,
  output logic                           o_selection_violation_flag,
  output logic [7:0]                     o_scope_select,
  output logic                           o_dash_visible,
  output logic [1:0]                     o_short_line_intensity_level
);

  // ==========================================================
  // functions
  function automatic logic [9:0] pat_mask(input scope_sel_pkg::dash_code_t c);
    logic [9:0] m;
    m = 10'h000;
    unique case ({c.enable, c.variant})
      2'b10:   m = scope_sel_pkg::PAT_SHORT;
      2'b11:   m = scope_sel_pkg::PAT_SLS;
      2'b01:   m = scope_sel_pkg::PAT_LONG;
      2'b00:   m = 10'h000;
    endcase
    return m;
  endfunction

  function automatic scope_sel_pkg::vel_class_t vel_class(
    input logic [11:0] ext);
    scope_sel_pkg::vel_class_t v;
    v = scope_sel_pkg::VEL_EIGHTH;
    if (ext >= scope_sel_pkg::EXT_HALF)
      v = scope_sel_pkg::VEL_NORMAL;
    else if (ext >= scope_sel_pkg::EXT_QUARTER)
      v = scope_sel_pkg::VEL_HALF;
    else if (ext >= scope_sel_pkg::EXT_EIGHTH)
      v = scope_sel_pkg::VEL_QUARTER;
    return v;
  endfunction

  // ==========================================================
  // state
  scope_sel_pkg::cmd_t        stage_r;
  logic [7:0]                 choice_r;
  logic [7:0]                 allow_r;
  logic [17:0]                dir_r;
  logic [17:0]                dir_nxt;
  logic [7:0]                 active_r;
  logic [7:0]                 scope_out_r;
  scope_sel_pkg::dash_code_t  dash_r;
  logic                       viol_r;
  logic [17:0]                saved_r;
  logic [23:0]                blink_cnt_r;
  logic                       blink_off_r;
  scope_sel_pkg::vel_class_t  vclass_r;
  logic [7:0]                 pre_cnt_r;
  logic [3:0]                 part_r;
  logic                       vis_r;

  // ==========================================================
  // decode of loads and staged bits
  wire logic        cap_w     = i_ph1 & i_phase_one_strobe;
  wire logic        ld_sp_w   = i_ph2 & i_load & i_select_load_enable;
  wire logic        ld_dir_w  = i_ph2 & i_load & i_directive_load_enable;
  wire logic        ld_act_w  = i_ph3 & i_phase_three_strobe;
  wire logic        sel_take_w = stage_r.set_bits[scope_sel_pkg::SEL_TAKE_BIT];
  wire logic        privilege_take_bit_w    = stage_r.set_bits[scope_sel_pkg::PRIVILEGE_TAKE_BIT_BIT];
  wire logic        dir_take_w = stage_r.set_bits[scope_sel_pkg::DIR_TAKE];
  wire logic [17:0] j_w       = stage_r.set_bits;
  wire logic [17:0] k_w       = stage_r.clr_bits;

  // J-K update of control bits, targets gated by take
  wire logic [17:0] jk_w      = (j_w & ~dir_r) | (~k_w & dir_r);
  wire logic [17:0] tgt_w     = dir_take_w ? j_w : dir_r;
  assign dir_nxt = (jk_w & scope_sel_pkg::DIR_JK_MASK) |
                   (tgt_w & scope_sel_pkg::DIR_TARGET_MASK);

  // scope_allowance check, one bit per scope
  wire logic        viol_w    = |(choice_r & ~allow_r);

  // blink gate from the directive blink bit
  wire logic        blink_en_w = dir_r[scope_sel_pkg::DIR_BLINK];
  wire logic        blink_gate_w = blink_en_w & blink_off_r;
  wire logic        blink_wrap_w =
    (blink_cnt_r == 24'(BLINK_HALF_CYC - 1));

  // dash timebase, stretched per velocity class
  wire logic [7:0]  pre_lim_w =
    8'((scope_sel_pkg::TICK_CYC << vclass_r) - 1);
  // a slower class left by the last line must not run the count past wrap
  wire logic        tick_w    = i_intensify & (pre_cnt_r >= pre_lim_w);
  wire logic [9:0]  onehot_w  = 10'(10'h001 << part_r);
  wire logic        flip_w    = |(onehot_w & pat_mask(dash_r));
  wire logic        ctr_rst_w = i_move |
    (i_line_start & i_restart_segment_each_line);
  wire logic        dashed_w  = dash_r.enable | dash_r.variant;

  // saved view selection
  wire logic [17:0] save_w = i_save_directive ? dir_r :
                             {2'b00, allow_r, choice_r};

  // ==========================================================
  // input staging
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
      stage_r <= '0;
    else if (cap_w)
      stage_r <= i_cmd;
  end

  // ==========================================================
  // scope choice and allowance
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      choice_r <= scope_sel_pkg::SCOPE_RESET;
      allow_r  <= scope_sel_pkg::SCOPE_RESET;
    end
    else
    begin
      if (ld_sp_w & sel_take_w)
        choice_r <= stage_r.set_bits[7:0];
      if (ld_sp_w & privilege_take_bit_w)
        allow_r <= stage_r.set_bits[7:0];
    end
  end

  // ==========================================================
  // directive register
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
      dir_r <= scope_sel_pkg::DIR_RESET;
    else if (ld_dir_w)
      dir_r <= dir_nxt;
  end

  // ==========================================================
  // violation flag and saved view
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      viol_r  <= 1'b0;
      saved_r <= '0;
    end
    else
    begin
      viol_r  <= viol_w;
      saved_r <= save_w;
    end
  end

  // ==========================================================
  // blink timer, free running half periods
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      blink_cnt_r <= 24'h000000;
      blink_off_r <= 1'b0;
    end
    else if (blink_wrap_w)
    begin
      blink_cnt_r <= 24'h000000;
      blink_off_r <= ~blink_off_r;
    end
    else
      blink_cnt_r <= blink_cnt_r + 24'h000001;
  end

  // ==========================================================
  // phase three output stage and blink gating
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      active_r    <= scope_sel_pkg::SCOPE_RESET;
      dash_r      <= '0;
      scope_out_r <= scope_sel_pkg::SCOPE_RESET;
    end
    else
    begin
      if (ld_act_w)
      begin
        active_r       <= choice_r;
        dash_r.enable  <= dir_r[scope_sel_pkg::DIR_DASH_EN];
        dash_r.variant <= dir_r[scope_sel_pkg::DIR_VARIANT];
      end
      scope_out_r <= blink_gate_w ? 8'h00 : active_r;
    end
  end

  // ==========================================================
  // velocity class caught at line start
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
      vclass_r <= scope_sel_pkg::VEL_NORMAL;
    else if (i_line_start)
      vclass_r <= vel_class(i_line_extent);
  end

  // ==========================================================
  // dash prescaler, part counter and toggle
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      pre_cnt_r <= 8'h00;
      part_r    <= 4'h0;
      vis_r     <= 1'b1;
    end
    else if (ctr_rst_w)
    begin
      pre_cnt_r <= 8'h00;
      part_r    <= 4'h0;
      vis_r     <= 1'b1;
    end
    else if (!dashed_w)
      vis_r <= 1'b1;
    else if (i_intensify)
    begin
      if (tick_w)
      begin
        pre_cnt_r <= 8'h00;
        part_r    <= (part_r == scope_sel_pkg::PARTS_LAST) ? 4'h0 :
                     part_r + 4'h1;
        vis_r     <= vis_r ^ flip_w;
      end
      else
        pre_cnt_r <= pre_cnt_r + 8'h01;
    end
  end

  // ==========================================================
  // outputs straight from flip-flops
  assign o_saved_value_lines          = saved_r;
  assign o_directive                  = dir_r;
  assign o_selection_violation_flag   = viol_r;
  assign o_scope_select               = scope_out_r;
  assign o_dash_visible               = vis_r;
  assign o_short_line_intensity_level = vclass_r;

  // ==========================================================
  // assertions
  property p_capture;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    cap_w |=> (stage_r == $past(i_cmd));
  endproperty
  a_capture: assert property (p_capture)
    else $error("staging did not capture command word");

  property p_choice_hold;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    !(ld_sp_w && sel_take_w) |=> $stable(choice_r);
  endproperty
  a_choice_hold: assert property (p_choice_hold)
    else $error("scope choice changed without take");

  property p_allow_load;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    (ld_sp_w && privilege_take_bit_w) |=> (allow_r == $past(stage_r.set_bits[7:0]));
  endproperty
  a_allow_load: assert property (p_allow_load)
    else $error("allowance not loaded under privilege");

  property p_allow_hold;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    !(ld_sp_w && privilege_take_bit_w) |=> $stable(allow_r);
  endproperty
  a_allow_hold: assert property (p_allow_hold)
    else $error("allowance changed without load");

  property p_target_hold;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    (ld_dir_w && !dir_take_w) |=> $stable(dir_r[11:4]);
  endproperty
  a_target_hold: assert property (p_target_hold)
    else $error("directive targets changed without take");

  property p_jk_set;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    (ld_dir_w && j_w[scope_sel_pkg::DIR_BLINK] &&
     !k_w[scope_sel_pkg::DIR_BLINK] &&
     !j_w[scope_sel_pkg::DIR_LINE_TYPE] &&
     !k_w[scope_sel_pkg::DIR_LINE_TYPE])
    |=> dir_r[scope_sel_pkg::DIR_BLINK] &&
        $stable(dir_r[scope_sel_pkg::DIR_LINE_TYPE]);
  endproperty
  a_jk_set: assert property (p_jk_set)
    else $error("directive bit not set individually");

  property p_violation;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    (|(choice_r & ~allow_r)) |=> o_selection_violation_flag;
  endproperty
  a_violation: assert property (p_violation)
    else $error("violation flag not raised");

  property p_blink_off;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    blink_gate_w |=> (o_scope_select == 8'h00);
  endproperty
  a_blink_off: assert property (p_blink_off)
    else $error("scope selected during blink off");

  sequence s_move;
    i_move;
  endsequence
  sequence s_fresh;
    (part_r == 4'h0) && vis_r && (pre_cnt_r == 8'h00);
  endsequence
  property p_move_restart;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    s_move |=> s_fresh;
  endproperty
  a_move_restart: assert property (p_move_restart)
    else $error("pattern did not restart on move");

  property p_freeze;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    (!i_intensify && !ctr_rst_w) |=> $stable(part_r) && $stable(pre_cnt_r);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("pattern advanced between lines");

  property p_level;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    (i_line_start && i_line_extent < scope_sel_pkg::EXT_EIGHTH)
    |=> (o_short_line_intensity_level == 2'b11);
  endproperty
  a_level: assert property (p_level)
    else $error("eighth velocity level wrong");

  property p_choice_load;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    (ld_sp_w && sel_take_w) |=> (choice_r == $past(stage_r.set_bits[7:0]));
  endproperty
  a_choice_load: assert property (p_choice_load)
    else $error("scope choice not loaded under take");

  property p_solid;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    !dashed_w |=> o_dash_visible;
  endproperty
  a_solid: assert property (p_solid)
    else $error("solid line not fully visible");

  property p_save_view;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    !i_save_directive |=>
      (o_saved_value_lines == {2'b00, $past(allow_r), $past(choice_r)});
  endproperty
  a_save_view: assert property (p_save_view)
    else $error("saved lines do not show choice and allowance");

endmodule

// >>> sim/cmd_source_model.sv
// command source model: drives the three-phase command cable
// assumes the block samples the cable on the rising edge of i_clk_sys
`timescale 1ns/1ps
module cmd_source_model
(
  // clock
  input  wire logic           i_clk_sys,
  // command cable
  output scope_sel_pkg::cmd_t o_cmd,
  output logic                o_ph1,
  output logic                o_ph2,
  output logic                o_ph3,
  output logic                o_phase_one_strobe,
  output logic                o_phase_three_strobe,
  output logic                o_load,
  output logic                o_select_load_enable,
  output logic                o_directive_load_enable
);

  // ==========================================================
  // idle cable
  initial
  begin
    {o_cmd, o_ph1, o_ph2, o_ph3} = '0;
    {o_phase_one_strobe, o_phase_three_strobe} = 2'h0;
    {o_load, o_select_load_enable, o_directive_load_enable} = 3'h0;
  end

  // ==========================================================
  // one transfer: phase one, two, three, one cycle each
  task send(input logic [17:0] s, c, input logic p1, se, de, p3);
    @(negedge i_clk_sys);
    o_cmd.set_bits = s;
    o_cmd.clr_bits = c;
    o_ph1 = 1'b1;
    o_phase_one_strobe = p1;
    @(negedge i_clk_sys);
    o_ph1 = 1'b0;
    o_phase_one_strobe = 1'b0;
    o_cmd = ~o_cmd; // word no longer held after capture
    o_ph2 = 1'b1;
    o_load = se | de;
    o_select_load_enable = se;
    o_directive_load_enable = de;
    @(negedge i_clk_sys);
    {o_ph2, o_load, o_select_load_enable, o_directive_load_enable} = 4'h0;
    o_ph3 = 1'b1;
    o_phase_three_strobe = p3;
    @(negedge i_clk_sys);
    o_ph3 = 1'b0;
    o_phase_three_strobe = 1'b0;
  endtask

endmodule

// >>> sim/tb_scope_select_dash_control.sv
// self-checking bench for the scope select / dash block
// assumes cmd_source_model drives the command cable
`timescale 1ns/1ps
module tb_scope_select_dash_control;

  // ==========================================================
  // signals
  typedef struct packed {logic [2:0] kind; logic [17:0] val;} note_t;
  logic                clk_sys, rst_b, ph1, ph2, ph3, p1s, p3s;
  logic                load, sel_en, dir_en, save_dir, move, lstart;
  logic                intens, restart, viol, dash;
  scope_sel_pkg::cmd_t cmd, m_stage;
  logic [11:0]         ext;
  logic [17:0]         saved, dirv, m_dir, cnt;
  logic [7:0]          sel, m_choice, m_allow, m_sel;
  logic [1:0]          lvl;
  logic [31:0]         rng;
  int                  num_errors, n_checks;
  note_t               notes[$];
  note_t               cur;
  logic [11:0]         exts[8];
  logic [1:0]          lv[8];

  // ==========================================================
  // clock
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // ==========================================================
  // design and command source
  scope_select_dash_control #(.BLINK_HALF_CYC(8)) dut
  (
    .i_clk_sys                    (clk_sys),
    .i_rst_b                      (rst_b),
    .i_cmd                        (cmd),
    .i_ph1                        (ph1),
    .i_ph2                        (ph2),
    .i_ph3                        (ph3),
    .i_phase_one_strobe           (p1s),
    .i_phase_three_strobe         (p3s),
    .i_load                       (load),
    .i_select_load_enable         (sel_en),
    .i_directive_load_enable      (dir_en),
    .i_save_directive             (save_dir),
    .i_move                       (move),
    .i_line_start                 (lstart),
    .i_intensify                  (intens),
    .i_line_extent                (ext),
    .i_restart_segment_each_line  (restart),
    .o_saved_value_lines          (saved),
    .o_directive                  (dirv),
    .o_selection_violation_flag   (viol),
    .o_scope_select               (sel),
    .o_dash_visible               (dash),
    .o_short_line_intensity_level (lvl)
  );

  cmd_source_model src
  (
    .i_clk_sys               (clk_sys),
    .o_cmd                   (cmd),
    .o_ph1                   (ph1),
    .o_ph2                   (ph2),
    .o_ph3                   (ph3),
    .o_phase_one_strobe      (p1s),
    .o_phase_three_strobe    (p3s),
    .o_load                  (load),
    .o_select_load_enable    (sel_en),
    .o_directive_load_enable (dir_en)
  );

  // ==========================================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  // set/clear per bit, targets only with the take bit
  function automatic logic [17:0] jk(input logic [17:0] d, s, c);
    logic [17:0] n;
    n = ((s & ~d) | (~c & d)) & scope_sel_pkg::DIR_JK_MASK;
    return n | ((s[3] ? s : d) & scope_sel_pkg::DIR_TARGET_MASK);
  endfunction

  task check(input logic [17:0] seen, exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task wrap_up;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task note(input logic [2:0] k, input logic [17:0] v);
    notes.push_back({k, v});
    @(negedge clk_sys);
  endtask

  // one transfer plus the reference model update
  task cmd_send(input logic [17:0] s, c, input logic p1, se, de, p3);
    src.send(s, c, p1, se, de, p3);
    if (p1)
      m_stage = {s, c};
    if (se & m_stage.set_bits[8])
      m_choice = m_stage.set_bits[7:0];
    if (se & m_stage.set_bits[16])
      m_allow = m_stage.set_bits[7:0];
    if (de)
      m_dir = jk(m_dir, m_stage.set_bits, m_stage.clr_bits);
    if (p3)
      m_sel = m_choice;
    repeat (3) @(negedge clk_sys);
  endtask

  task check_all;
    note(3'h0, m_dir);
    note(3'h2, {17'h0, |(m_choice & ~m_allow)});
    note(3'h3, {10'h0, m_sel});
    note(3'h1, {2'h0, m_allow, m_choice});
    save_dir = 1'b1;
    repeat (2) @(negedge clk_sys);
    note(3'h1, m_dir);
    save_dir = 1'b0;
  endtask

  task line_go(input logic [11:0] e);
    move = 1'b1;
    @(negedge clk_sys);
    move = 1'b0;
    ext = e;
    lstart = 1'b1;
    @(negedge clk_sys);
    lstart = 1'b0;
    intens = 1'b1;
  endtask

  // sample mid-part, toggle expectation per wired code
  task run_dash(input logic [11:0] e, input logic [9:0] pat, input int per,
                input int n);
    logic v;
    v = 1'b1;
    line_go(e);
    repeat (per / 2) @(negedge clk_sys);
    for (int p = 0; p < n; p++)
    begin
      note(3'h4, {17'h0, v});
      if (pat[p])
        v = ~v;
      repeat (per - 1) @(negedge clk_sys);
    end
    intens = 1'b0;
  endtask

  // ==========================================================
  // watcher: compares the oldest note each cycle
  always @(posedge clk_sys)
  begin
    if (notes.size() > 0)
    begin
      cur = notes.pop_front();
      case (cur.kind)
        3'h0: check(dirv, cur.val);
        3'h1: check(saved, cur.val);
        3'h2: check({17'h0, viol}, cur.val);
        3'h3: check({10'h0, sel}, cur.val);
        3'h4: check({17'h0, dash}, cur.val);
        default: check({16'h0, lvl}, cur.val);
      endcase
    end
  end

  // hang guard
  initial
  begin
    repeat (100000) @(posedge clk_sys);
    num_errors++;
    wrap_up;
  end

  // ==========================================================
  // main sequence
  initial
  begin
    {rst_b, save_dir, move, lstart, intens, restart} = 6'h00;
    ext = 12'h000;
    {m_dir, m_choice, m_allow, m_sel, m_stage} = '0;
    num_errors = 0;
    n_checks = 0;
    rng = 32'h0000001E;
    exts = '{12'hFFF, 12'h040, 12'h03F, 12'h020, 12'h01F, 12'h010,
             12'h00F, 12'h000};
    lv = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3};
    // reset values, four cycles in reset
    note(3'h0, 18'h00000);
    note(3'h3, 18'h00000);
    note(3'h4, 18'h00001);
    note(3'h5, 18'h00000);
    rst_b = 1'b1;
    // loads, refusals, violation, missing strobes and enables
    cmd_send(18'h10103, 18'h0, 1'b1, 1'b1, 1'b0, 1'b1);
    check_all;
    cmd_send(18'h00105, 18'h0, 1'b1, 1'b1, 1'b0, 1'b1);
    check_all;
    cmd_send(18'h10007, 18'h0, 1'b1, 1'b1, 1'b0, 1'b1);
    check_all;
    cmd_send(18'h101FF, 18'h0, 1'b0, 1'b1, 1'b0, 1'b1);
    check_all;
    cmd_send(18'h10101, 18'h0, 1'b1, 1'b0, 1'b0, 1'b1);
    check_all;
    cmd_send(18'h10101, 18'h0, 1'b1, 1'b1, 1'b0, 1'b0);
    check_all;
    // random directive words, blink kept clear
    for (int i = 0; i < 8; i++)
    begin
      rng = xs(rng);
      m_stage.set_bits = rng[17:0] & ~18'h01000;
      rng = xs(rng);
      cmd_send(m_stage.set_bits, rng[17:0] | 18'h01000, 1'b1, 1'b0, 1'b1,
               1'b1);
      check_all;
    end
    // blink: off half of every period gates selection
    cmd_send(18'h01000, 18'h0, 1'b1, 1'b0, 1'b1, 1'b1);
    cnt = 18'h0;
    repeat (32)
    begin
      @(negedge clk_sys);
      if (sel === 8'h00)
        cnt++;
    end
    check(cnt, 18'h00010);
    cmd_send(18'h0, 18'h01000, 1'b1, 1'b0, 1'b1, 1'b1);
    check_all;
    // every dash code at normal velocity
    for (int k = 0; k < 4; k++)
    begin
      cmd_send({2'h0, k[0], k[1], 14'h0}, {2'h0, ~k[0], ~k[1], 14'h0},
               1'b1, 1'b0, 1'b1, 1'b1);
      run_dash(12'h064, (k == 0) ? 10'h000 : (k == 2) ?
               scope_sel_pkg::PAT_SHORT : (k == 1) ?
               scope_sel_pkg::PAT_LONG : scope_sel_pkg::PAT_SLS, 25, 10);
    end
    // quarter velocity stretches each part four times
    cmd_send(18'h04000, 18'h08000, 1'b1, 1'b0, 1'b1, 1'b1);
    run_dash(12'h014, scope_sel_pkg::PAT_SHORT, 100, 3);
    // count frozen between lines; restart option resets it
    for (int r = 0; r < 2; r++)
    begin
      restart = 1'b0;
      line_go(12'h064);
      repeat (37) @(negedge clk_sys);
      intens = 1'b0;
      repeat (9) @(negedge clk_sys);
      note(3'h4, 18'h00000);
      restart = r[0];
      lstart = 1'b1;
      @(negedge clk_sys);
      lstart = 1'b0;
      intens = 1'b1;
      repeat (3) @(negedge clk_sys);
      note(3'h4, {17'h0, r[0]});
      intens = 1'b0;
    end
    // velocity classes and correction levels
    for (int i = 0; i < 8; i++)
    begin
      ext = exts[i];
      lstart = 1'b1;
      @(negedge clk_sys);
      lstart = 1'b0;
      repeat (2) @(negedge clk_sys);
      note(3'h5, {16'h0, lv[i]});
    end
    for (int i = 0; i < 20 && notes.size() > 0; i++)
      @(negedge clk_sys);
    // notes left over mean the watcher never saw their results
    if (notes.size() > 0)
      num_errors++;
    wrap_up;
  end

endmodule
